// ### verilog/ir_measurement_mode_sequencer.sv
// Mode sequencer and result hand-off of a four-channel infrared sensor
// Operation
// - Address pins pick switch mode or bus address
// - Switch mode: alert on difference outside thresholds
// - Switch mode repeats using stored memory conditions
// - Power-down low stops every function
// - Start in standby; mode changes via standby
// - Standby keeps registers, blocks memory access
// - Code 001 with enable: memory access, no measuring
// - Memory writes need key A5
// - Single shot measures once, returns to standby
// - Continuous 0 measures back to back
// - Continuous 1-3 alternate measurement and wait
// - Mode write to standby aborts measurement, keeps old result
// - Stored result sets ready flag and alert
// - Read-out start clears ready; overrun only if ready
// - Results frozen until second status read
// - Unread result: ready stays, overrun set
// - Open read-out: new result dropped, overrun set
// - Overrun clears at read start if ready
// - Reads mid-measurement return previous result
// - Reset loads defaults and standby
`timescale 1ns/10ps
`include "ir_seq_params.svh"

module ir_measurement_mode_sequencer #(
  parameter logic [23:0] MEAS_BASE = `IRS_MEAS_BASE,
  parameter logic [23:0] WAIT_ONE = `IRS_WAIT_ONE,
  parameter logic [23:0] WAIT_TWO = `IRS_WAIT_TWO,
  parameter logic [23:0] WAIT_THREE = `IRS_WAIT_THREE
) (
  // Core clock and reset
  input wire logic mclk,
  input wire logic reset,
  // Device pins
  input wire logic powerDownN,
  input wire logic addrSelectLo,
  input wire logic addrSelectHi,
  output logic alert,
  // Serial side, link clock domain
  input wire logic linkClk,
  input wire logic linkReset,
  input wire ir_seq_pkg::host_cmd_s hostCmd,
  output ir_seq_pkg::link_stat_s linkStatus,
  // Configuration and analog front end
  input wire logic intEnable,
  input wire ir_seq_pkg::nvm_cfg_s nvmCfg,
  input wire ir_seq_pkg::sample_s adcSample,
  // Results and status
  output ir_seq_pkg::sample_s sampleData,
  output logic sampleReadyFlag,
  output logic sampleOverrunFlag,
  output logic [2:0] opMode,
  output logic [6:0] busAddress,
  output logic busEnable,
  output logic nvmWriteGrant
);

  ir_seq_pkg::link_state_s l;
  ir_seq_pkg::link_state_s next_l;
  ir_seq_pkg::main_state_s r;
  ir_seq_pkg::main_state_s next_r;
  logic [4:0] ev;
  logic switchMode;
  logic complete;
  logic rdS;
  logic rdE;

  function automatic logic [23:0] measCycles(input logic [2:0] fc);
    measCycles = MEAS_BASE << fc;
  endfunction

  function automatic logic [23:0] waitCycles(input logic [2:0] code);
    case (code)
      `IRS_MODE_CONT1: waitCycles = WAIT_ONE;
      `IRS_MODE_CONT2: waitCycles = WAIT_TWO;
      `IRS_MODE_CONT3: waitCycles = WAIT_THREE;
      default: waitCycles = 24'h000000;
    endcase
  endfunction

  function automatic logic signed [17:0] chanDiff(input logic [15:0] a,
                                                  input logic [15:0] b);
    chanDiff = 18'(signed'(a)) - 18'(signed'(b));
  endfunction

  function automatic logic outside(input logic signed [17:0] d,
                                   input ir_seq_pkg::nvm_cfg_s c);
    outside = (d > 18'(c.upper)) || (d < 18'(c.lower));
  endfunction

  function automatic logic withinBand(input logic signed [17:0] d,
                                      input ir_seq_pkg::nvm_cfg_s c);
    logic signed [17:0] h;
    h = signed'({2'h0, c.hyst});
    withinBand = (d <= 18'(c.upper) - h) && (d >= 18'(c.lower) + h);
  endfunction

  function automatic ir_seq_pkg::main_state_s defaults();
    ir_seq_pkg::main_state_s d;
    d = '0;
    d.st = ir_seq_pkg::ST_PDOWN;
    d.mode = `IRS_MODE_STBY;
    return d;
  endfunction

  // Link domain: capture each host command and flip its toggle
  always_comb begin
    next_l = l;
    next_l.sy1.sampleReadyFlag = r.ready;
    next_l.sy1.sampleOverrunFlag = r.overrun;
    next_l.sy1.opMode = r.mode;
    next_l.sy2 = l.sy1;
    if (hostCmd.modeWrite) begin
      next_l.modeVal = hostCmd.opModeSelect;
      next_l.nvmEn = hostCmd.nvmAccessEnable;
      next_l.filterVal = hostCmd.filterCutoffSelect;
      next_l.tg[`IRS_TG_MODE] = ~l.tg[`IRS_TG_MODE];
    end
    if (hostCmd.keyWrite) begin
      next_l.keyVal = hostCmd.nvmWriteKey;
      next_l.tg[`IRS_TG_KEY] = ~l.tg[`IRS_TG_KEY];
    end
    if (hostCmd.readStart) begin
      next_l.tg[`IRS_TG_RDSTART] = ~l.tg[`IRS_TG_RDSTART];
    end
    if (hostCmd.statusSecondRead) begin
      next_l.tg[`IRS_TG_RDEND] = ~l.tg[`IRS_TG_RDEND];
    end
    if (hostCmd.nvmWrite) begin
      next_l.tg[`IRS_TG_NVMWR] = ~l.tg[`IRS_TG_NVMWR];
    end
  end

  always_ff @(posedge linkClk or posedge linkReset) begin
    if (linkReset) begin
      l <= '0;
    end else begin
      l <= next_l;
    end
  end

  assign linkStatus = l.sy2;

  // Core domain; payload words are stable long before their toggle lands
  always_comb begin
    next_r = r;
    complete = 1'b0;
    next_r.pin1 = {powerDownN, addrSelectHi, addrSelectLo};
    next_r.pin2 = r.pin1;
    next_r.tg1 = l.tg;
    next_r.tg2 = r.tg1;
    next_r.tg3 = r.tg2;
    next_r.grant = 1'b0;
    ev = r.tg2 ^ r.tg3;
    switchMode = &r.pin2[1:0];
    // Bus events other than memory writes are ignored in switch mode since the bus is idle there
    rdS = ev[`IRS_TG_RDSTART] & ~switchMode;
    rdE = ev[`IRS_TG_RDEND] & ~switchMode;
    next_r.busAddr = `IRS_ADDR_BASE + {5'h00, r.pin2[1:0]};
    next_r.busEn = ~switchMode && r.st != ir_seq_pkg::ST_PDOWN;
    if (ev[`IRS_TG_KEY] && !switchMode) begin
      next_r.key = l.keyVal;
    end
    case (r.st)
      ir_seq_pkg::ST_PDOWN: begin
        next_r.st = ir_seq_pkg::ST_STBY;
      end
      ir_seq_pkg::ST_STBY: begin
        if (switchMode) begin
          next_r.st = ir_seq_pkg::ST_MEAS;
          next_r.timer = measCycles(nvmCfg.filterCutoffSelect);
        end else if (r.mode == `IRS_MODE_SINGLE || r.mode[2]) begin
          next_r.st = ir_seq_pkg::ST_MEAS;
          next_r.timer = measCycles(r.filter);
        end else if (r.mode == `IRS_MODE_NVM && r.nvmEn) begin
          next_r.st = ir_seq_pkg::ST_NVM;
        end
      end
      ir_seq_pkg::ST_MEAS: begin
        if (r.timer <= 24'h000001) begin
          complete = 1'b1;
          if (switchMode) begin
            next_r.timer = waitCycles(nvmCfg.modeCode);
          end else begin
            next_r.timer = waitCycles(r.mode);
          end
          if (!switchMode && r.mode == `IRS_MODE_SINGLE) begin
            next_r.st = ir_seq_pkg::ST_HOLD;
          end else if (next_r.timer != 24'h000000) begin
            next_r.st = ir_seq_pkg::ST_WAIT;
          end else if (switchMode) begin
            next_r.timer = measCycles(nvmCfg.filterCutoffSelect);
          end else begin
            next_r.timer = measCycles(r.filter);
          end
        end else begin
          next_r.timer = r.timer - 24'h000001;
        end
      end
      ir_seq_pkg::ST_WAIT: begin
        if (r.timer <= 24'h000001) begin
          next_r.st = ir_seq_pkg::ST_MEAS;
          if (switchMode) begin
            next_r.timer = measCycles(nvmCfg.filterCutoffSelect);
          end else begin
            next_r.timer = measCycles(r.filter);
          end
        end else begin
          next_r.timer = r.timer - 24'h000001;
        end
      end
      ir_seq_pkg::ST_HOLD: begin
        // Analog side is idle here; the second status read or a mode write to standby releases it
        if (rdE) begin
          next_r.st = ir_seq_pkg::ST_STBY;
          next_r.mode = `IRS_MODE_STBY;
        end
      end
      ir_seq_pkg::ST_NVM: begin
        if (ev[`IRS_TG_NVMWR] && r.key == `IRS_NVM_KEY) begin
          next_r.grant = 1'b1;
        end
      end
      default: begin
        next_r.st = ir_seq_pkg::ST_STBY;
      end
    endcase
    // Leaving switch mode ends the stored-condition loop; the host mode decides
    if (!switchMode && r.mode == `IRS_MODE_STBY &&
        (r.st == ir_seq_pkg::ST_MEAS || r.st == ir_seq_pkg::ST_WAIT)) begin
      next_r.st = ir_seq_pkg::ST_STBY;
      complete = 1'b0;
    end
    // A jump between two active modes is refused: the host goes via standby
    if (ev[`IRS_TG_MODE] && !switchMode) begin
      if (r.mode == `IRS_MODE_STBY || l.modeVal == `IRS_MODE_STBY) begin
        next_r.mode = l.modeVal;
        next_r.nvmEn = l.nvmEn;
        next_r.filter = l.filterVal;
        if (r.st != ir_seq_pkg::ST_PDOWN) begin
          next_r.st = ir_seq_pkg::ST_STBY;
        end
        complete = complete & (l.modeVal == r.mode);
      end
    end
    if (rdS || rdE) begin
      next_r.ready = 1'b0;
      if (r.ready) begin
        next_r.overrun = 1'b0;
      end
    end
    next_r.protect = rdE ? 1'b0 : (r.protect | rdS);
    // The set below follows the clears so a finishing sample is not lost
    if (complete && !switchMode) begin
      if (r.protect && !rdE) begin
        next_r.overrun = 1'b1;
      end else begin
        next_r.result = adcSample;
        next_r.ready = 1'b1;
        if (r.ready) begin
          next_r.overrun = 1'b1;
        end
      end
    end
    if (complete && switchMode) begin
      if (outside(chanDiff(adcSample.chanOne, adcSample.chanThree), nvmCfg) ||
          outside(chanDiff(adcSample.chanTwo, adcSample.chanFour), nvmCfg)) begin
        next_r.swAlert = 1'b1;
      end else if (withinBand(chanDiff(adcSample.chanOne, adcSample.chanThree), nvmCfg) &&
                   withinBand(chanDiff(adcSample.chanTwo, adcSample.chanFour), nvmCfg)) begin
        next_r.swAlert = 1'b0;
      end
    end
    if (!switchMode) begin
      next_r.swAlert = 1'b0;
    end
    next_r.alert = switchMode ? next_r.swAlert : (intEnable & next_r.ready);
    // Power-down behaves as a hardware reset; only the synchronisers run
    if (!r.pin2[2]) begin
      next_r = defaults();
      next_r.pin1 = {powerDownN, addrSelectHi, addrSelectLo};
      next_r.pin2 = r.pin1;
      next_r.tg1 = l.tg;
      next_r.tg2 = r.tg1;
      next_r.tg3 = r.tg2;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      r <= '0;
      r.st <= ir_seq_pkg::ST_PDOWN;
    end else begin
      r <= next_r;
    end
  end

  assign alert = r.alert;
  assign sampleData = r.result;
  assign sampleReadyFlag = r.ready;
  assign sampleOverrunFlag = r.overrun;
  assign opMode = r.mode;
  assign busAddress = r.busAddr;
  assign busEnable = r.busEn;
  assign nvmWriteGrant = r.grant;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  property p_addr_map;
    !switchMode && r.pin2[2] |=> busAddress == `IRS_ADDR_BASE + {5'h00, $past(r.pin2[1:0])};
  endproperty
  a_addr_map: assert property (p_addr_map) else $error("bus address wrong");

  property p_switch_no_bus;
    switchMode && $past(switchMode) |-> !busEnable;
  endproperty
  a_switch_no_bus: assert property (p_switch_no_bus) else $error("bus on in switch");

  property p_pdown_clears;
    !r.pin2[2] |=> r.st == ir_seq_pkg::ST_PDOWN && !sampleReadyFlag && opMode == 3'h0;
  endproperty
  a_pdown_clears: assert property (p_pdown_clears) else $error("power-down ignored");

  property p_grant_key;
    nvmWriteGrant |-> $past(r.key) == `IRS_NVM_KEY && $past(r.st) == ir_seq_pkg::ST_NVM;
  endproperty
  a_grant_key: assert property (p_grant_key) else $error("memory write unlocked");

  property p_single_done;
    r.st == ir_seq_pkg::ST_HOLD && rdE && r.pin2[2] |=> opMode == 3'h0;
  endproperty
  a_single_done: assert property (p_single_done) else $error("no return to standby");

  property p_overrun_skip;
    complete && !switchMode && r.ready && !r.protect && r.pin2[2]
      |=> sampleReadyFlag && sampleOverrunFlag;
  endproperty
  a_overrun_skip: assert property (p_overrun_skip) else $error("skip not flagged");

  property p_discard;
    complete && !switchMode && r.protect && !rdE && r.pin2[2]
      |=> $stable(sampleData) && sampleOverrunFlag;
  endproperty
  a_discard: assert property (p_discard) else $error("protected data changed");

  property p_read_clear;
    rdS && !rdE && !complete && r.pin2[2] |=> !sampleReadyFlag && r.protect;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read start kept flag");

  property p_alert_ready;
    !switchMode && intEnable && $past(intEnable) && r.pin2[2] ##1 r.pin2[2]
      |-> alert == sampleReadyFlag;
  endproperty
  a_alert_ready: assert property (p_alert_ready) else $error("alert mismatch");

  property p_stby_no_grant;
    r.st == ir_seq_pkg::ST_STBY |=> !nvmWriteGrant;
  endproperty
  a_stby_no_grant: assert property (p_stby_no_grant) else $error("write in standby");

  property p_nvm_no_meas;
    r.st == ir_seq_pkg::ST_NVM && r.pin2[2] |=> $stable(sampleData);
  endproperty
  a_nvm_no_meas: assert property (p_nvm_no_meas) else $error("measured in memory mode");

  c_single: cover property (r.st == ir_seq_pkg::ST_HOLD ##[1:1000] opMode == 3'h0);
  c_overrun: cover property (sampleOverrunFlag && sampleReadyFlag);
  c_nvm_write: cover property (nvmWriteGrant);
  c_switch_alert: cover property (switchMode && alert);

endmodule

// ### verilog/ir_seq_params.svh
// Constants for the infrared measurement mode sequencer
`ifndef IR_SEQ_PARAMS_SVH
`define IR_SEQ_PARAMS_SVH
`define IRS_ADDR_BASE 7'h64
`define IRS_MODE_STBY 3'h0
`define IRS_MODE_NVM 3'h1
`define IRS_MODE_SINGLE 3'h2
`define IRS_MODE_CONT0 3'h4
`define IRS_MODE_CONT1 3'h5
`define IRS_MODE_CONT2 3'h6
`define IRS_MODE_CONT3 3'h7
`define IRS_NVM_KEY 8'hA5
`define IRS_TG_MODE 0
`define IRS_TG_KEY 1
`define IRS_TG_RDSTART 2
`define IRS_TG_RDEND 3
`define IRS_TG_NVMWR 4
`define IRS_MEAS_BASE 24'h000100
`define IRS_WAIT_ONE 24'h000400
`define IRS_WAIT_TWO 24'h000800
`define IRS_WAIT_THREE 24'h001000
`endif

// ### verilog/ir_seq_pkg.sv
// Types shared by the infrared measurement mode sequencer
package ir_seq_pkg;
  typedef enum logic [2:0] {
    ST_STBY = 3'h0,
    ST_MEAS = 3'h1,
    ST_WAIT = 3'h3,
    ST_HOLD = 3'h5,
    ST_NVM = 3'h2,
    ST_PDOWN = 3'h4
  } seq_state_e;

  typedef struct packed {
    logic [15:0] chanOne;
    logic [15:0] chanTwo;
    logic [15:0] chanThree;
    logic [15:0] chanFour;
    logic [15:0] temp;
  } sample_s;

  typedef struct packed {
    logic modeWrite;
    logic [2:0] opModeSelect;
    logic nvmAccessEnable;
    logic [2:0] filterCutoffSelect;
    logic keyWrite;
    logic [7:0] nvmWriteKey;
    logic readStart;
    logic statusSecondRead;
    logic nvmWrite;
  } host_cmd_s;

  typedef struct packed {
    logic sampleReadyFlag;
    logic sampleOverrunFlag;
    logic [2:0] opMode;
  } link_stat_s;

  typedef struct packed {
    logic signed [15:0] upper;
    logic signed [15:0] lower;
    logic [15:0] hyst;
    logic [2:0] filterCutoffSelect;
    logic [2:0] modeCode;
  } nvm_cfg_s;

  typedef struct packed {
    logic [2:0] modeVal;
    logic nvmEn;
    logic [2:0] filterVal;
    logic [7:0] keyVal;
    logic [4:0] tg;
    link_stat_s sy1;
    link_stat_s sy2;
  } link_state_s;

  typedef struct packed {
    seq_state_e st;
    logic [2:0] pin1;
    logic [2:0] pin2;
    logic [4:0] tg1;
    logic [4:0] tg2;
    logic [4:0] tg3;
    logic [2:0] mode;
    logic nvmEn;
    logic [2:0] filter;
    logic [7:0] key;
    logic [23:0] timer;
    logic ready;
    logic overrun;
    logic protect;
    sample_s result;
    logic swAlert;
    logic alert;
    logic grant;
    logic [6:0] busAddr;
    logic busEn;
  } main_state_s;
endpackage

// ### verification/ir_host_model.sv
// Host controller model issuing one-cycle commands in the link clock domain
`timescale 1ns/10ps
module ir_host_model (
  // Link clock and reset
  input wire logic linkClk,
  input wire logic linkReset,
  // Device side
  input wire ir_seq_pkg::link_stat_s linkStatus,
  input wire logic switchMode,
  output ir_seq_pkg::host_cmd_s hostCmd
);
  initial hostCmd = '0;

  // Kind 0 mode, 1 key, 2 read start, 3 second status read, 4 memory write
  task automatic send(input int kind, input logic [2:0] mode, input logic en,
      input logic [2:0] filt, input logic [7:0] key);
    ir_seq_pkg::host_cmd_s c;
    c = '0;
    if (switchMode || linkReset) return;
    // Status reads in standby upset the device, so the host never makes them
    if (kind inside {2, 3} && linkStatus.opMode === 3'h0) return;
    c.modeWrite = (kind == 0);
    c.opModeSelect = mode;
    c.nvmAccessEnable = en;
    c.filterCutoffSelect = filt;
    c.keyWrite = (kind == 1);
    c.nvmWriteKey = key;
    c.readStart = (kind == 2);
    c.statusSecondRead = (kind == 3);
    c.nvmWrite = (kind == 4);
    @(posedge linkClk);
    hostCmd <= c;
    @(posedge linkClk);
    hostCmd <= '0;
    // Idle link cycle keeps same-kind pulses apart
    @(posedge linkClk);
  endtask
endmodule

// ### verification/ir_measurement_mode_sequencer_tb.sv
// Self-checking bench for the infrared measurement mode sequencer
`timescale 1ns/10ps
module ir_measurement_mode_sequencer_tb;
  typedef struct packed {
    logic hi;
    logic lo;
    logic [2:0] mode;
    logic en;
    logic [6:0] addr;
    logic bus;
    logic [2:0] expMode;
  } row_s;
  localparam logic [23:0] MEAS = 24'h000020;
  logic mclk = 1'h0;
  logic linkClk = 1'h0;
  logic reset = 1'h1;
  logic linkReset = 1'h1;
  logic powerDownN = 1'h1;
  logic addrSelectLo = 1'h0;
  logic addrSelectHi = 1'h0;
  logic intEnable = 1'h1;
  ir_seq_pkg::nvm_cfg_s nvmCfg = '0;
  ir_seq_pkg::sample_s adcSample = '0;
  ir_seq_pkg::host_cmd_s hostCmd;
  ir_seq_pkg::link_stat_s linkStatus;
  ir_seq_pkg::sample_s sampleData;
  ir_seq_pkg::sample_s held;
  logic alert, sampleReadyFlag, sampleOverrunFlag, busEnable, nvmWriteGrant;
  logic [2:0] opMode;
  logic [6:0] busAddress;
  int fail_count = 0;
  int cmp_count = 0;
  int grants = 0;
  int g;
  row_s r;
  row_s rows [8] = '{
    '{1'h0, 1'h0, 3'h2, 1'h0, 7'h64, 1'h1, 3'h2},
    '{1'h0, 1'h0, 3'h4, 1'h0, 7'h64, 1'h1, 3'h4},
    '{1'h0, 1'h1, 3'h5, 1'h0, 7'h65, 1'h1, 3'h5},
    '{1'h1, 1'h0, 3'h6, 1'h0, 7'h66, 1'h1, 3'h6},
    '{1'h0, 1'h0, 3'h7, 1'h0, 7'h64, 1'h1, 3'h7},
    '{1'h0, 1'h0, 3'h1, 1'h0, 7'h64, 1'h1, 3'h1},
    '{1'h0, 1'h0, 3'h1, 1'h1, 7'h64, 1'h1, 3'h1},
    '{1'h1, 1'h1, 3'h4, 1'h0, 7'h00, 1'h0, 3'h0}
  };

  always #5 mclk = ~mclk;
  // Link rising edges land on mclk falling edges, never on its sampling edge
  always #40 linkClk = ~linkClk;
  always @(posedge mclk) if (nvmWriteGrant === 1'h1) grants <= grants + 1;

  ir_measurement_mode_sequencer #(.MEAS_BASE(MEAS), .WAIT_ONE(24'h000040),
      .WAIT_TWO(24'h000080), .WAIT_THREE(24'h000100)) uut (
    .mclk(mclk), .reset(reset), .powerDownN(powerDownN), .addrSelectLo(addrSelectLo),
    .addrSelectHi(addrSelectHi), .alert(alert), .linkClk(linkClk), .linkReset(linkReset),
    .hostCmd(hostCmd), .linkStatus(linkStatus), .intEnable(intEnable), .nvmCfg(nvmCfg),
    .adcSample(adcSample), .sampleData(sampleData), .sampleReadyFlag(sampleReadyFlag),
    .sampleOverrunFlag(sampleOverrunFlag), .opMode(opMode), .busAddress(busAddress),
    .busEnable(busEnable), .nvmWriteGrant(nvmWriteGrant));

  ir_host_model host (.linkClk(linkClk), .linkReset(linkReset), .linkStatus(linkStatus),
    .switchMode(addrSelectLo & addrSelectHi), .hostCmd(hostCmd));

  task automatic check(input logic [79:0] got, input logic [79:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  function automatic logic [2:0] probe(input int sel);
    case (sel)
      0: return opMode;
      1: return {2'h0, sampleReadyFlag};
      2: return {2'h0, sampleOverrunFlag};
      default: return {2'h0, alert};
    endcase
  endfunction

  task automatic wait_for(input int sel, input logic [2:0] val);
    for (int i = 0; i < 3000; i++) begin
      @(posedge mclk);
      #1;
      if (probe(sel) === val) return;
    end
    fail_count++;
    end_of_test();
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  initial begin
    cycles(4);
    reset <= 1'h0;
    linkReset <= 1'h0;
    cycles(6);
    check({opMode, sampleReadyFlag, sampleOverrunFlag, nvmWriteGrant, alert}, 7'h00);
    foreach (rows[i]) begin
      r = rows[i];
      @(posedge mclk);
      addrSelectHi <= r.hi;
      addrSelectLo <= r.lo;
      adcSample <= {5{16'h1200 + 16'(i)}};
      cycles(6);
      check(busEnable, r.bus);
      if (r.bus) begin
        check(busAddress, r.addr);
        host.send(0, r.mode, r.en, 3'h0, 8'h00);
        wait_for(0, r.expMode);
        check(opMode, r.expMode);
        if (r.expMode[2] | r.expMode[1]) begin
          if (r.expMode[2]) begin
            // A result left over from the previous row must not pass for this one
            cycles(24);
            host.send(3, 3'h0, 1'h0, 3'h0, 8'h00);
          end
          wait_for(1, 3'h1);
          check(sampleData, adcSample);
          cycles(2);
          check(alert, intEnable);
          host.send(2, 3'h0, 1'h0, 3'h0, 8'h00);
          wait_for(1, 3'h0);
          check(sampleOverrunFlag, 1'h0);
          host.send(3, 3'h0, 1'h0, 3'h0, 8'h00);
          if (r.expMode == 3'h2) begin
            wait_for(0, 3'h0);
            check(opMode, 3'h0);
          end
        end
        host.send(0, 3'h0, 1'h0, 3'h0, 8'h00);
        wait_for(0, 3'h0);
      end
    end
    // Switch mode: thresholds +-100, hysteresis 10, no wait between measurements
    @(posedge mclk);
    nvmCfg <= '{16'sh0064, -16'sh0064, 16'h000A, 3'h0, 3'h4};
    adcSample <= '{16'h0200, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    wait_for(3, 3'h1);
    check(alert, 1'h1);
    @(posedge mclk);
    adcSample <= '{16'h005F, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
    cycles(200);
    check(alert, 1'h1);
    @(posedge mclk);
    adcSample <= '0;
    wait_for(3, 3'h0);
    check(alert, 1'h0);
    @(posedge mclk);
    addrSelectHi <= 1'h0;
    addrSelectLo <= 1'h0;
    cycles(6);
    // Unread result, then a read-out left open across a completion
    host.send(0, 3'h4, 1'h0, 3'h0, 8'h00);
    wait_for(0, 3'h4);
    cycles(24);
    host.send(3, 3'h0, 1'h0, 3'h0, 8'h00);
    wait_for(2, 3'h1);
    check(sampleReadyFlag, 1'h1);
    host.send(2, 3'h0, 1'h0, 3'h0, 8'h00);
    wait_for(2, 3'h0);
    check(sampleReadyFlag, 1'h0);
    held = sampleData;
    @(posedge mclk);
    adcSample <= {5{16'hBEEF}};
    wait_for(2, 3'h1);
    check(sampleData, held);
    host.send(3, 3'h0, 1'h0, 3'h0, 8'h00);
    wait_for(1, 3'h1);
    check(sampleData, {5{16'hBEEF}});
    host.send(0, 3'h0, 1'h0, 3'h0, 8'h00);
    wait_for(0, 3'h0);
    // Aborted long measurement keeps the old result
    held = sampleData;
    @(posedge mclk);
    adcSample <= {5{16'h7A7A}};
    host.send(0, 3'h4, 1'h0, 3'h3, 8'h00);
    wait_for(0, 3'h4);
    cycles(20);
    host.send(0, 3'h0, 1'h0, 3'h0, 8'h00);
    wait_for(0, 3'h0);
    cycles(300);
    check(sampleData, held);
    check(linkStatus.opMode, 3'h0);
    // Memory writes: refused in standby and with a wrong key
    g = grants;
    host.send(1, 3'h0, 1'h0, 3'h0, 8'hA5);
    host.send(4, 3'h0, 1'h0, 3'h0, 8'h00);
    cycles(10);
    check(80'(grants), 80'(g));
    host.send(0, 3'h1, 1'h1, 3'h0, 8'h00);
    wait_for(0, 3'h1);
    host.send(1, 3'h0, 1'h0, 3'h0, 8'h5A);
    host.send(4, 3'h0, 1'h0, 3'h0, 8'h00);
    cycles(10);
    check(80'(grants), 80'(g));
    host.send(1, 3'h0, 1'h0, 3'h0, 8'hA5);
    host.send(4, 3'h0, 1'h0, 3'h0, 8'h00);
    cycles(10);
    check(80'(grants), 80'(g + 1));
    check(sampleData, held);
    host.send(0, 3'h0, 1'h0, 3'h0, 8'h00);
    wait_for(0, 3'h0);
    // Power-down in mid-measurement
    host.send(0, 3'h4, 1'h0, 3'h0, 8'h00);
    wait_for(0, 3'h4);
    @(posedge mclk);
    powerDownN <= 1'h0;
    cycles(5);
    check({opMode, sampleReadyFlag, busEnable}, 5'h00);
    @(posedge mclk);
    powerDownN <= 1'h1;
    cycles(100);
    check({opMode, sampleReadyFlag, busEnable}, 5'h01);
    end_of_test();
  end
endmodule
